// ---- rtl/qts_pkg.sv ----
package qts_pkg;

  // ***************************************************************
  // Timebase and timing
  // ***************************************************************
  localparam longint unsigned QTS_CLK_HZ       = 64'd100_000_000;
  localparam longint unsigned QTS_SEC_PER_MIN  = 64'd60;
  localparam longint unsigned QTS_WAIT20_MIN   = 64'd2;
  localparam longint unsigned QTS_IDLE_MIN     = 64'd10;
  localparam longint unsigned QTS_DEB_MS       = 64'd20;
  localparam longint unsigned QTS_MS_PER_SEC   = 64'd1000;

  // Longest waits are exact products, debounce rounds down
  localparam logic [35:0] QTS_WAIT20_CYC =
    36'(QTS_WAIT20_MIN * QTS_SEC_PER_MIN * QTS_CLK_HZ);
  localparam logic [35:0] QTS_IDLE_CYC =
    36'(QTS_IDLE_MIN * QTS_SEC_PER_MIN * QTS_CLK_HZ);
  localparam logic [23:0] QTS_DEB_CYC =
    24'(QTS_DEB_MS * QTS_CLK_HZ / QTS_MS_PER_SEC);

  // ***************************************************************
  // Step numbering and display codes
  // ***************************************************************
  localparam logic [5:0] QTS_STEP_FIRST     = 6'h01;
  localparam logic [5:0] QTS_STEP_SENS_FIRST = 6'h0e;
  localparam logic [5:0] QTS_STEP_OUT_FIRST = 6'h18;
  localparam logic [5:0] QTS_STEP_LAST      = 6'h21;
  localparam logic [3:0] QTS_DIGIT_2        = 4'h2;
  localparam logic [3:0] QTS_DIGIT_8        = 4'h8;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [11:0] QTS_ADDR_CTRL   = 12'h000;
  localparam logic [11:0] QTS_ADDR_STATUS = 12'h004;
  localparam logic        QTS_CTRL_RST    = 1'b1;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [2:0] {
    QTS_ST_IDLE   = 3'b000,
    QTS_ST_WAIT20 = 3'b001,
    QTS_ST_READY  = 3'b010,
    QTS_ST_STEP   = 3'b011,
    QTS_ST_RESULT = 3'b100,
    QTS_ST_RUN    = 3'b101
  } qts_state_e_t;

  typedef struct packed {
    logic       hi_on;
    logic [3:0] hi;
    logic       hi_dp;
    logic       lo_on;
    logic [3:0] lo;
    logic       lo_dp;
  } qts_disp_t;

  typedef struct packed {
    logic       button;
    logic       occupied;
    logic       enthalpy_contact;
    logic       lps1;
    logic       lps2;
    logic       relay_closed;
    logic       hdr_60hz;
    logic [3:0] hdr_type;
    logic [3:0] hdr_comp;
    logic [7:0] dip;
    logic [9:0] sensor_ok;
  } qts_pins_t;

  typedef struct packed {
    logic [6:0]   rsvd;
    logic         occupied;
    logic         unit_start;
    logic         alarm;
    qts_disp_t    disp;
    logic [5:0]   step;
    logic         test_en;
    logic [2:0]   state;
  } qts_status_t;

  typedef struct packed {
    qts_pins_t    ps1;
    qts_pins_t    ps2;
    logic         btn_stable;
    logic [23:0]  deb_cnt;
    logic [35:0]  timer;
    qts_state_e_t state;
    logic [5:0]   step;
    qts_disp_t    disp;
    logic         alarm;
    logic         unit_start;
    logic         test_mode;
    logic         act_pulse;
    logic [5:0]   act_step;
    logic         test_en;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
  } qts_regs_t;

  localparam qts_regs_t QTS_REGS_RST = '{
    state:   QTS_ST_IDLE,
    test_en: QTS_CTRL_RST,
    default: '0
  };

endpackage : qts_pkg

// ---- rtl/qts_sequencer.sv ----
// Our own choices: register access over APB and the register offsets.
module qts_sequencer
  import qts_pkg::*;
#(
  parameter logic [35:0] P_WAIT20_CYC = QTS_WAIT20_CYC,
  parameter logic [35:0] P_IDLE_CYC   = QTS_IDLE_CYC,
  parameter logic [23:0] P_DEB_CYC    = QTS_DEB_CYC
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  // Operator and contacts
  input  wire logic        i_button,
  input  wire logic        i_occupied,
  input  wire logic        i_enthalpy_contact,
  input  wire logic        i_lps1,
  input  wire logic        i_lps2,
  input  wire logic        i_relay_closed,
  // Configuration header and option switches
  input  wire logic        i_hdr_60hz,
  input  wire logic [3:0]  i_hdr_type,
  input  wire logic [3:0]  i_hdr_comp,
  input  wire logic [7:0]  i_dip,
  // Sensor and potentiometer checks
  input  wire logic [9:0]  i_sensor_ok,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  // Display and lamps
  output qts_disp_t        o_disp,
  output logic             o_alarm_light,
  output logic             o_unit_start,
  output logic             o_test_mode,
  // Output-step relay action
  output logic             o_action_pulse,
  output logic [5:0]       o_action_step,
  // APB answer
  output logic             o_pready,
  output logic             o_pslverr,
  output logic [31:0]      o_prdata
);

  // ***************************************************************
  // Display code helpers
  // ***************************************************************

  // Step number with a point after each digit
  // Tens come from three compares rather than a divider; steps
  // stop at 33, so the range never reaches forty
  function automatic qts_disp_t step_code(input logic [5:0] s);
    qts_disp_t d;
    logic [5:0] ones;
    d    = '0;
    ones = s;
    d.lo_on = 1'b1;
    d.lo_dp = 1'b1;
    if (s >= 6'h1e) begin
      d.hi = 4'h3;
      ones = s - 6'h1e;
    end else if (s >= 6'h14) begin
      d.hi = 4'h2;
      ones = s - 6'h14;
    end else if (s >= 6'h0a) begin
      d.hi = 4'h1;
      ones = s - 6'h0a;
    end
    if (s >= 6'h0a) begin
      d.hi_on = 1'b1;
      d.hi_dp = 1'b1;
    end
    d.lo = ones[3:0];
    return d;
  endfunction : step_code

  // Result for a step, never with points
  // Output steps report the relay feedback pin; the relay itself is
  // driven outside the block on the action pulse
  function automatic qts_disp_t result_code(input logic [5:0] s,
                                            input qts_pins_t p);
    qts_disp_t d;
    logic b;
    d = '0;
    b = 1'b0;
    d.lo_on = 1'b1;
    case (s)
      6'h01: begin
        d.hi_on = 1'b1;
        d.lo    = p.hdr_type;
      end
      6'h02: d.lo = p.hdr_comp;
      6'h03: d.lo = {3'h0, p.dip[5]} + {3'h0, p.dip[6]};
      6'h04: begin
        d.hi_on = 1'b1;
        d.hi    = p.hdr_60hz ? 4'h6 : 4'h5;
      end
      6'h05: b = p.dip[1];
      6'h06: b = p.dip[2];
      6'h07: b = p.dip[3];
      6'h08: b = p.dip[4];
      6'h09: b = p.enthalpy_contact;
      6'h0a: b = p.lps1;
      6'h0b: b = p.lps2;
      6'h0c: b = 1'b1;
      6'h0d: b = 1'b1;
      default: begin
        // Sensor group, else output group
        // Sensor steps index the good-input bits from step 14 up
        if (s < QTS_STEP_OUT_FIRST) begin
          b = p.sensor_ok[4'(s - QTS_STEP_SENS_FIRST)];
        end else begin
          b = p.relay_closed;
        end
      end
    endcase
    if (s >= 6'h05) begin
      d.lo = {3'h0, b};
    end
    return d;
  endfunction : result_code

  // ***************************************************************
  // State and pin gathering
  // ***************************************************************
  qts_regs_t   r_q;
  qts_regs_t   r_d;
  qts_pins_t   pins_in;
  qts_status_t status;

  // All pins sampled as one group
  // Nothing reads these before the two synchroniser stages
  assign pins_in = '{
    button:           i_button,
    occupied:         i_occupied,
    enthalpy_contact: i_enthalpy_contact,
    lps1:             i_lps1,
    lps2:             i_lps2,
    relay_closed:     i_relay_closed,
    hdr_60hz:         i_hdr_60hz,
    hdr_type:         i_hdr_type,
    hdr_comp:         i_hdr_comp,
    dip:              i_dip,
    sensor_ok:        i_sensor_ok
  };

  // Status word seen by software
  // Low 25 bits used, the rest read as zero
  assign status = '{
    rsvd:       '0,
    occupied:   r_q.ps2.occupied,
    unit_start: r_q.unit_start,
    alarm:      r_q.alarm,
    disp:       r_q.disp,
    step:       r_q.step,
    test_en:    r_q.test_en,
    state:      r_q.state
  };

  // ***************************************************************
  // Next state
  // ***************************************************************
  // One pass builds the whole next state from the current one
  always_comb begin
    logic press;
    logic tmo;
    press = 1'b0;
    tmo   = 1'b0;
    r_d   = r_q;

    // Two-stage synchroniser, first stage feeds only the second
    // Header and switches ride the same flops: they are static, so a
    // word torn across an edge settles within one cycle
    r_d.ps1 = pins_in;
    r_d.ps2 = r_q.ps1;

    // Debounce: level must hold a full window before it counts
    // Trade-off: each press pays the whole window in latency, but a
    // bounce shorter than the window never advances the sequence
    if (r_q.ps2.button != r_q.btn_stable) begin
      if (r_q.deb_cnt >= P_DEB_CYC - 24'h000001) begin
        r_d.btn_stable = r_q.ps2.button;
        r_d.deb_cnt    = '0;
        press          = r_q.ps2.button;
      end else begin
        r_d.deb_cnt = r_q.deb_cnt + 24'h000001;
      end
    end else begin
      r_d.deb_cnt = '0;
    end

    // Free timer, cleared at every press-driven move, on entry to wait 20 and when occupied drops
    // One timer serves the 20 wait and the test idle limit, as only
    // one of them can run at a time
    r_d.timer     = r_q.timer + 36'h000000001;
    r_d.act_pulse = 1'b0;

    case (r_q.state)
      // Wait for the occupied contact
      QTS_ST_IDLE: begin
        if (r_q.ps2.occupied) begin
          r_d.state = QTS_ST_WAIT20;
          r_d.timer = '0;
        end
      end
      // A press enters test when test_en is set; silence starts the unit
      QTS_ST_WAIT20: begin
        tmo = (r_q.timer >= P_WAIT20_CYC - 36'h000000001);
        if (press && r_q.test_en) begin
          r_d.state = QTS_ST_READY;
          r_d.timer = '0;
        end else if (tmo) begin
          r_d.state = QTS_ST_RUN;
        end
      end
      // Test ready; the next press opens step 1
      QTS_ST_READY: begin
        tmo = (r_q.timer >= P_IDLE_CYC - 36'h000000001);
        if (press) begin
          r_d.state = QTS_ST_STEP;
          r_d.step  = QTS_STEP_FIRST;
          r_d.timer = '0;
        end else if (tmo) begin
          r_d.state = QTS_ST_RUN;
        end
      end
      // Step number shown; the next press runs the step
      QTS_ST_STEP: begin
        tmo = (r_q.timer >= P_IDLE_CYC - 36'h000000001);
        if (press) begin
          r_d.state = QTS_ST_RESULT;
          r_d.timer = '0;
          // Output steps drive their relay on the second press
          if (r_q.step >= QTS_STEP_OUT_FIRST) begin
            r_d.act_pulse = 1'b1;
            r_d.act_step  = r_q.step;
          end
        end else if (tmo) begin
          r_d.state = QTS_ST_RUN;
        end
      end
      // Result shown; the next press moves one step forward
      QTS_ST_RESULT: begin
        tmo = (r_q.timer >= P_IDLE_CYC - 36'h000000001);
        if (press) begin
          r_d.timer = '0;
          // Forward only; after the last step the unit starts
          if (r_q.step == QTS_STEP_LAST) begin
            r_d.state = QTS_ST_RUN;
          end else begin
            r_d.state = QTS_ST_STEP;
            r_d.step  = r_q.step + 6'h01;
          end
        end else if (tmo) begin
          r_d.state = QTS_ST_RUN;
        end
      end
      // Normal operation until occupied drops
      QTS_ST_RUN: begin
        r_d.state = QTS_ST_RUN;
      end
      // Unused code: recover to idle
      default: begin
        r_d.state = QTS_ST_IDLE;
      end
    endcase

    // Losing occupied aborts everything except an action pulse set in the same cycle; the only way back to step 1
    // The step clears too, so a re-entry always opens at step 1
    if (!r_q.ps2.occupied) begin
      r_d.state = QTS_ST_IDLE;
      r_d.step  = '0;
      r_d.timer = '0;
    end

    // Display and lamps follow the next state
    r_d.disp = '0;
    case (r_d.state)
      // Code 20 while the operator is awaited
      QTS_ST_WAIT20: begin
        r_d.disp.hi_on = 1'b1;
        r_d.disp.hi    = QTS_DIGIT_2;
        r_d.disp.lo_on = 1'b1;
      end
      // Code 88: test program ready
      QTS_ST_READY: begin
        r_d.disp.hi_on = 1'b1;
        r_d.disp.hi    = QTS_DIGIT_8;
        r_d.disp.lo_on = 1'b1;
        r_d.disp.lo    = QTS_DIGIT_8;
      end
      QTS_ST_STEP:   r_d.disp = step_code(r_d.step);
      QTS_ST_RESULT: r_d.disp = result_code(r_d.step, r_q.ps2);
      default:       r_d.disp = '0;
    endcase
    // Alarm lamp marks the whole test program, 88 included
    r_d.test_mode  = (r_d.state == QTS_ST_READY) ||
                     (r_d.state == QTS_ST_STEP)  ||
                     (r_d.state == QTS_ST_RESULT);
    r_d.alarm      = r_d.test_mode;
    r_d.unit_start = (r_d.state == QTS_ST_RUN);

    // APB: answer in the access cycle, slverr on unmapped words
    // Setup is taken only while ready is low, so it is taken once
    r_d.pready  = 1'b0;
    r_d.pslverr = 1'b0;
    if (i_psel && !i_penable && !r_q.pready) begin
      r_d.pready = 1'b1;
      case (i_paddr)
        QTS_ADDR_CTRL:   r_d.prdata = {31'h00000000, r_q.test_en};
        QTS_ADDR_STATUS: r_d.prdata = status;
        default: begin
          r_d.prdata  = '0;
          r_d.pslverr = 1'b1;
        end
      endcase
    end
    // A write lands only at the access edge, with ready standing;
    // status is read-only, so a write there is dropped without error
    if (i_psel && i_penable && r_q.pready && i_pwrite &&
        (i_paddr == QTS_ADDR_CTRL) && i_pstrb[0]) begin
      r_d.test_en = i_pwdata[0];
    end
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  // Asynchronous reset loads constants only
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r_q <= QTS_REGS_RST;
    end else begin
      r_q <= r_d;
    end
  end

  // Outputs straight from flops
  // No output passes through logic, so the pins cannot glitch
  assign o_disp         = r_q.disp;
  assign o_alarm_light  = r_q.alarm;
  assign o_unit_start   = r_q.unit_start;
  assign o_test_mode    = r_q.test_mode;
  assign o_action_pulse = r_q.act_pulse;
  assign o_action_step  = r_q.act_step;
  assign o_pready       = r_q.pready;
  assign o_pslverr      = r_q.pslverr;
  assign o_prdata       = r_q.prdata;

endmodule : qts_sequencer

// ---- bench/qts_seq_properties.sv ----
module qts_seq_properties
  import qts_pkg::*;
(
  // Clock and reset
  input wire logic       i_clk,
  input wire logic       i_arst_n,
  // Watched inputs
  input wire logic       i_button,
  input wire logic       i_occupied,
  input wire logic       i_psel,
  input wire logic       i_penable,
  // Watched outputs
  input wire qts_disp_t  o_disp,
  input wire logic       o_alarm_light,
  input wire logic       o_unit_start,
  input wire logic       o_test_mode,
  input wire logic       o_action_pulse,
  input wire logic [5:0] o_action_step,
  input wire logic       o_pready,
  input wire logic       o_pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  // Bus phases as the slave sees them
  sequence s_setup;
    i_psel && !i_penable && !o_pready;
  endsequence
  sequence s_access;
    i_psel && i_penable && o_pready;
  endsequence

  apb_answer_a: assert property (s_setup |=> s_access)
    else $error("no zero-wait answer to setup");
  apb_single_a: assert property (o_pready |=> !o_pready)
    else $error("ready stood two cycles");
  apb_err_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  // Sync delay allows a few cycles before the start must drop
  occ_start_a: assert property (!i_occupied [*6] |-> !o_unit_start)
    else $error("unit start without occupied");
  alarm_mode_a: assert property (o_alarm_light == o_test_mode)
    else $error("alarm and test mode differ");
  start_alarm_a: assert property (o_unit_start |-> !o_alarm_light)
    else $error("start while in test");
  press_alarm_a: assert property ($rose(o_alarm_light) |->
    $past(i_button, 3)) else $error("test entered without press");
  step_dp_a: assert property (o_test_mode && o_disp.hi_on &&
    o_disp.hi_dp |-> o_disp.lo_dp) else $error("step point missing");
  result_dp_a: assert property (o_test_mode && o_disp.lo_on &&
    !o_disp.lo_dp |-> !o_disp.hi_dp) else $error("result with point");
  act_step_a: assert property (o_action_pulse |=>
    o_action_step >= 6'd24 && o_action_step <= 6'd33)
    else $error("action outside output group");
  act_once_a: assert property (o_action_pulse |=> !o_action_pulse)
    else $error("action pulse too long");
  entry_88_a: assert property ($rose(o_test_mode) |->
    o_disp.hi == QTS_DIGIT_8 && o_disp.lo == QTS_DIGIT_8 &&
    o_disp.hi_on && o_disp.lo_on && !o_disp.hi_dp && !o_disp.lo_dp)
    else $error("test entry without 88");
endmodule : qts_seq_properties

bind qts_sequencer qts_seq_properties u_props (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_button(i_button),
  .i_occupied(i_occupied), .i_psel(i_psel), .i_penable(i_penable),
  .o_disp(o_disp), .o_alarm_light(o_alarm_light),
  .o_unit_start(o_unit_start), .o_test_mode(o_test_mode),
  .o_action_pulse(o_action_pulse), .o_action_step(o_action_step),
  .o_pready(o_pready), .o_pslverr(o_pslverr)
);

// ---- bench/qts_operator.sv ----
module qts_operator (
  // Clock and request
  input  wire logic i_clk,
  input  wire logic i_press,
  // Button pin and activity
  output logic      o_button,
  output logic      o_busy
);
  timeunit 1ns;
  timeprecision 1ps;

  // ***************************************************************
  // Operator
  // ***************************************************************
  initial begin
    o_button = 1'b0;
    o_busy   = 1'b0;
  end

  // One press: a short contact bounce first, so a naive edge
  // detector would advance twice
  always @(posedge i_clk) begin
    if (i_press) begin
      o_busy   <= 1'b1;
      o_button <= 1'b1;
      @(posedge i_clk);
      o_button <= 1'b0;
      repeat (2) @(posedge i_clk);
      o_button <= 1'b1;
      repeat (12) @(posedge i_clk);
      o_button <= 1'b0;
      repeat (12) @(posedge i_clk);
      o_busy   <= 1'b0;
    end
  end
endmodule : qts_operator

// ---- bench/qts_sequencer_tb.sv ----
module quick_test_sequencer_tb;
  import qts_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ***************************************************************
  // Signals
  // ***************************************************************
  localparam logic [11:0] D20 = {1'b1, QTS_DIGIT_2, 2'b01, 4'h0, 1'b0};
  localparam logic [11:0] D88 = {1'b1, QTS_DIGIT_8, 2'b01, QTS_DIGIT_8, 1'b0};
  logic        clk, arst_n, occ, ent, lps1, lps2, relay, hz60;
  logic        psel, pen, pwr, press, btn, busy, err;
  logic [3:0]  htype, hcomp, pstrb;
  logic [7:0]  dip;
  logic [9:0]  sok;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  qts_disp_t   disp;
  logic        alarm, ustart, tmode, apulse, pready, pslverr;
  logic [5:0]  astep;
  int          error_cnt = 0;
  int          n_checks = 0;
  int          cyc = 0;

  // Short counts keep the run brief
  qts_sequencer #(.P_WAIT20_CYC(36'd200), .P_IDLE_CYC(36'd400),
    .P_DEB_CYC(24'd4)) dut (
    .i_clk(clk), .i_arst_n(arst_n), .i_button(btn), .i_occupied(occ),
    .i_enthalpy_contact(ent), .i_lps1(lps1), .i_lps2(lps2),
    .i_relay_closed(relay), .i_hdr_60hz(hz60), .i_hdr_type(htype),
    .i_hdr_comp(hcomp), .i_dip(dip), .i_sensor_ok(sok), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_pstrb(pstrb), .o_disp(disp),
    .o_alarm_light(alarm), .o_unit_start(ustart), .o_test_mode(tmode),
    .o_action_pulse(apulse), .o_action_step(astep), .o_pready(pready),
    .o_pslverr(pslverr), .o_prdata(prdata));

  qts_operator u_op (.i_clk(clk), .i_press(press), .o_button(btn),
    .o_busy(busy));

  // ***************************************************************
  // Helpers
  // ***************************************************************
  function automatic logic [11:0] stepd(int n);
    if (n < 10) return {6'h00, 1'b1, 4'(n), 1'b1};
    return {1'b1, 4'(n / 10), 2'b11, 4'(n % 10), 1'b1};
  endfunction : stepd

  // Expected result code from the pins as driven
  function automatic logic [11:0] resd(int n);
    logic [3:0] v;
    if (n == 1) return {6'h20, 1'b1, htype, 1'b0};
    if (n == 4) return {1'b1, hz60 ? 4'h6 : 4'h5, 2'b01, 4'h0, 1'b0};
    if (n == 2) v = hcomp;
    else if (n == 3) v = 4'(dip[5]) + 4'(dip[6]);
    else if (n <= 8) v = 4'(dip[n - 4]);
    else if (n == 9) v = 4'(ent);
    else if (n == 10) v = 4'(lps1);
    else if (n == 11) v = 4'(lps2);
    else if (n <= 13) v = 4'h1;
    else if (n <= 23) v = 4'(sok[n - 14]);
    else v = 4'(relay);
    return {6'h00, 1'b1, v, 1'b0};
  endfunction : resd

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // Unlit high digit value is left unchecked
  task automatic cd(input logic [11:0] e);
    chk(32'(disp & (e[11] ? 12'hfff : 12'h87f)), 32'(e));
  endtask : cd

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // Request stands until ready is seen high at a rising edge
    do @(posedge clk); while (pready !== 1'b1);
    rd   = prdata;
    err  = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb

  task automatic push;
    @(posedge clk);
    press <= 1'b1;
    @(posedge clk);
    press <= 1'b0;
    @(posedge clk);
    while (busy === 1'b1) @(posedge clk);
  endtask : push

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  task stop_test;
    if (error_cnt == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  // ***************************************************************
  // Clock, watchdog, sequence
  // ***************************************************************
  always #5 clk = ~clk;

  // Ceiling well above the roughly 3200 cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test;
    end
  end

  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    {occ, lps2, relay, psel, pen, pwr, press} = '0;
    {ent, lps1, hz60} = 3'b111;
    htype = 4'h1;
    hcomp = 4'h2;
    dip = 8'h2a;
    sok = 10'h2b5;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
    wt(2);
    arst_n <= 1'b1;
    wt(8);
    chk(32'(ustart), 32'h0);
    apb(1'b0, QTS_ADDR_STATUS, '0);
    chk(rd, 32'h8);
    apb(1'b0, 12'h008, '0);
    chk(rd, 32'h0);
    chk(32'(err), 32'h1);
    occ <= 1'b1;
    wt(8);
    cd(D20);
    apb(1'b0, QTS_ADDR_STATUS, '0);
    chk(rd & ~32'h3f0, {7'h0, 3'b100, D20, 6'h0, 4'h9});
    // Test entry disabled: press at 20 must be ignored
    apb(1'b1, QTS_ADDR_CTRL, 32'h0);
    push;
    cd(D20);
    wt(260);
    chk(32'(ustart), 32'h1);
    apb(1'b1, QTS_ADDR_CTRL, 32'h1);
    occ <= 1'b0;
    wt(8);
    chk(32'(ustart), 32'h0);
    occ <= 1'b1;
    wt(8);
    push;
    cd(D88);
    chk(32'(alarm), 32'h1);
    for (int n = 1; n <= 33; n++) begin
      push;
      cd(stepd(n));
      relay <= n[0];
      push;
      cd(resd(n));
      if (n > 23) chk(32'(astep), 32'(n));
    end
    push;
    chk(32'(ustart), 32'h1);
    push;
    chk(32'(ustart), 32'h1);
    occ <= 1'b0;
    wt(8);
    occ <= 1'b1;
    wt(8);
    push;
    push;
    cd(stepd(1));
    wt(300);
    push;
    cd(resd(1));
    wt(300);
    chk(32'(alarm), 32'h1);
    wt(150);
    chk(32'(ustart), 32'h1);
    stop_test;
  end
endmodule : quick_test_sequencer_tb
